// >>> design/bit_stream_if.sv
// One serial bit stream with its per-bit strobe
`timescale 1ns/1ps
interface bit_stream_if;
	logic step;
	logic bit_v;
	modport src (output step, output bit_v);
	modport snk (input step, input bit_v);
endinterface : bit_stream_if

// >>> design/line_test.sv
// Per-channel test patterns, loop codes, QRSS and loopback with Avalon-MM registers
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "line_test_cfg.svh"
module line_test import line_test_pkg::*; #(
	parameter int unsigned QUAL_T1_CYCLES = `LOOP_QUAL_S * `T1_RATE_HZ,
	parameter int unsigned QUAL_E1_CYCLES = `LOOP_QUAL_S * `E1_RATE_HZ
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic host_mode_i,
	input wire logic auto_all_ones_pin_i,
	input wire logic [7:0] all_ones_request_pin_i,
	input wire logic [15:0] loop_pin_i,
	input wire logic [7:0] receive_loss_of_signal_i,
	input wire logic [7:0] tx_line_clock_i,
	input wire logic [7:0] tx_positive_data_in_i,
	input wire logic [7:0] tx_negative_data_in_i,
	input wire logic [7:0] rx_clock_i,
	input wire logic [7:0] rx_pos_i,
	input wire logic [7:0] rx_neg_i,
	output logic [7:0] tx_pos_o,
	output logic [7:0] tx_neg_o,
	output logic [7:0] analog_loop_o,
	output logic [7:0] remote_loop_o,
	output logic [7:0] digital_loop_o,
	output logic [7:0] irq_o
);
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic [2:0] global_q;
	logic [11:0] ctrl_q [`CHANNELS];
	logic [2:0] stat_w [`CHANNELS];
	logic [31:0] rd_w;
	logic [7:0] ch_off_w;
	logic ch_hit_w;
	logic [2:0] ch_idx_w;
	logic e1_w;
	logic auto_ones_w;
	logic [23:0] limit_w;

	assign e1_w = global_q[`GLB_E1_BIT];
	// Auto all-ones comes from the pin when strapped, else from the register
	assign auto_ones_w = host_mode_i ? global_q[`GLB_AUTO_ONES_BIT] : auto_all_ones_pin_i;
	assign limit_w = e1_w ? QUAL_E1_CYCLES[23:0] : QUAL_T1_CYCLES[23:0];
	assign ch_off_w = address_i - `CH_BASE;
	assign ch_hit_w = (address_i >= `CH_BASE) && (address_i < (`CH_BASE + `CH_SPAN))
		&& (address_i[1:0] == 2'h0);
	assign ch_idx_w = ch_off_w[5:3];

	// One wait cycle per access; the answer lands where waitrequest falls
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			waitrequest_q <= 1'b1;
		end else begin
			waitrequest_q <= !((read_i || write_i) && waitrequest_q);
		end
	end

	always_comb begin
		rd_w = 32'h0000_0000;
		if (address_i == `GLOBAL_OFS) begin
			rd_w = {29'h0000_0000, global_q};
		end else if (ch_hit_w && !ch_off_w[2]) begin
			rd_w = {20'h00000, ctrl_q[ch_idx_w]};
		end else if (ch_hit_w) begin
			rd_w = {29'h0000_0000, stat_w[ch_idx_w]};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			readdata_q <= 32'h0000_0000;
		end else if (read_i && waitrequest_q) begin
			readdata_q <= rd_w;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			global_q <= `GLOBAL_RESET;
			for (int i = 0; i < `CHANNELS; i++) begin
				ctrl_q[i] <= `CTRL_RESET;
			end
		end else if (write_i && !waitrequest_q) begin
			if (address_i == `GLOBAL_OFS) begin
				if (byteenable_i[0]) begin
					global_q <= writedata_i[2:0];
				end
			end else if (ch_hit_w && !ch_off_w[2]) begin
				if (byteenable_i[0]) begin
					ctrl_q[ch_idx_w][7:0] <= writedata_i[7:0];
				end
				if (byteenable_i[1]) begin
					ctrl_q[ch_idx_w][11:8] <= writedata_i[11:8];
				end
			end
		end
	end

	assign readdata_o = readdata_q;
	assign waitrequest_o = waitrequest_q;

	for (genvar g = 0; g < `CHANNELS; g++) begin : gen_ch
		bit_stream_if tx_s ();
		bit_stream_if rx_s ();
		auto_state_t state_q;
		loopback_t lb_w;
		logic txclk_prev_q, rxclk_prev_q, tx_edge_w, rx_edge_w, edge_w;
		logic [2:0] tps_w;
		logic [1:0] ldm_w;
		logic analog_w, remote_w, digital_w, ones_w, prbs_on_w, up_on_w, down_on_w;
		logic auto_on_w, want_down_w, want_prev_q, restart_w, qual_w, gen_bit_w, chk_bit_w;
		logic detected_q, detected_prev_q, flag_prev_q, err_w;
		logic ber_prev_q, bpv_prev_q, ber_pend_q, bpv_pend_q, last_pol_q;
		logic mark_w, ami_w, bpv_use_w, ber_use_w;
		logic [2:0] phase_q;
		logic [6:0] win_q;
		logic [2:0] errs_q;
		logic synced_q, prbs_flag_q;
		logic tx_pos_q, tx_neg_q, analog_q, remote_q, digital_q, irq_q;

		assign tps_w = ctrl_q[g][2:0];
		assign ldm_w = ctrl_q[g][4:3];
		assign tx_edge_w = tx_line_clock_i[g] && !txclk_prev_q;
		assign rx_edge_w = rx_clock_i[g] && !rxclk_prev_q;

		always_comb begin
			lb_w = LB_NONE;
			if (!host_mode_i) begin
				case (loop_pin_i[2*g+1 -: 2])
					2'h1: lb_w = LB_ANALOG;
					2'h2: lb_w = LB_REMOTE;
					2'h3: lb_w = LB_DIGITAL;
					default: lb_w = LB_NONE;
				endcase
			end else if (ctrl_q[g][7]) begin
				case (ctrl_q[g][6:5])
					2'h0: lb_w = LB_DUAL;
					2'h1: lb_w = LB_ANALOG;
					2'h2: lb_w = LB_REMOTE;
					default: lb_w = LB_DIGITAL;
				endcase
			end
		end

		assign analog_w = (lb_w == LB_ANALOG);
		assign digital_w = (lb_w == LB_DIGITAL) || (lb_w == LB_DUAL);
		assign remote_w = (lb_w == LB_REMOTE) || (lb_w == LB_DUAL) || (state_q == AUTO_LOOPED);
		assign ones_w = (host_mode_i ? (tps_w == `PAT_ONES) : all_ones_request_pin_i[g])
			|| (auto_ones_w && receive_loss_of_signal_i[g]);
		assign prbs_on_w = host_mode_i && (tps_w == `PAT_QRSS);
		assign up_on_w = host_mode_i && (tps_w == `PAT_UP);
		assign down_on_w = host_mode_i && (tps_w == `PAT_DOWN);
		assign auto_on_w = host_mode_i && (ldm_w == `DET_AUTO) && (tps_w != `PAT_UP);
		assign want_down_w = (host_mode_i && ldm_w == `DET_DOWN)
			|| (auto_on_w && state_q == AUTO_LOOPED);
		assign restart_w = (want_down_w != want_prev_q);
		// Remote loop runs off the recovered clock and ignores the transmit side
		assign edge_w = remote_w ? rx_edge_w : tx_edge_w;

		assign tx_s.step = tx_edge_w && prbs_on_w && !remote_w;
		assign tx_s.bit_v = 1'b0;
		assign rx_s.step = rx_edge_w;
		assign rx_s.bit_v = rx_pos_i[g] || rx_neg_i[g];

		prbs_engine u_gen (
			.clock_i(clock_i),
			.rst_i(rst_i),
			.s(tx_s),
			.e1_mode_i(e1_w),
			.check_i(1'b0),
			.bit_o(gen_bit_w)
		);

		prbs_engine u_chk (
			.clock_i(clock_i),
			.rst_i(rst_i),
			.s(rx_s),
			.e1_mode_i(e1_w),
			.check_i(1'b1),
			.bit_o(chk_bit_w)
		);

		loop_code_detector u_det (
			.clock_i(clock_i),
			.rst_i(rst_i),
			.rx(rx_s),
			.want_down_i(want_down_w),
			.restart_i(restart_w),
			.limit_i(limit_w),
			.qualified_o(qual_w)
		);

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				txclk_prev_q <= 1'b0;
				rxclk_prev_q <= 1'b0;
				want_prev_q <= 1'b0;
			end else begin
				txclk_prev_q <= tx_line_clock_i[g];
				rxclk_prev_q <= rx_clock_i[g];
				want_prev_q <= want_down_w;
			end
		end

		// Automatic loop-code sequence
		always_ff @(posedge clock_i) begin
			if (rst_i || !auto_on_w) begin
				state_q <= AUTO_OFF;
			end else begin
				case (state_q)
					AUTO_OFF: state_q <= AUTO_WATCH_UP;
					AUTO_WATCH_UP: begin
						if (qual_w && !analog_w) begin
							state_q <= AUTO_LOOPED;
						end
					end
					AUTO_LOOPED: begin
						if (qual_w) begin
							state_q <= AUTO_WATCH_UP;
						end
					end
					default: state_q <= AUTO_OFF;
				endcase
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i || !host_mode_i || ldm_w == `DET_OFF) begin
				detected_q <= 1'b0;
			end else if (ldm_w != `DET_AUTO) begin
				detected_q <= qual_w;
			end else if (!auto_on_w || state_q == AUTO_OFF) begin
				detected_q <= 1'b0;
			end else if (state_q == AUTO_WATCH_UP && qual_w && !analog_w) begin
				detected_q <= 1'b1;
			end else if (state_q == AUTO_LOOPED && qual_w) begin
				detected_q <= 1'b0;
			end
		end

		// Insert controls sampled at transmit clock edges; arm wins over consume
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				ber_prev_q <= 1'b0;
				bpv_prev_q <= 1'b0;
				ber_pend_q <= 1'b0;
				bpv_pend_q <= 1'b0;
			end else if (tx_edge_w) begin
				ber_prev_q <= ctrl_q[g][`CTRL_INS_BER_BIT];
				bpv_prev_q <= ctrl_q[g][`CTRL_INS_BPV_BIT];
				ber_pend_q <= (ctrl_q[g][`CTRL_INS_BER_BIT] && !ber_prev_q)
					|| (ber_pend_q && !ber_use_w);
				bpv_pend_q <= (ctrl_q[g][`CTRL_INS_BPV_BIT] && !bpv_prev_q)
					|| (bpv_pend_q && !bpv_use_w);
			end
		end

		always_comb begin
			mark_w = 1'b0;
			ami_w = 1'b1;
			if (ones_w) begin
				mark_w = 1'b1;
			end else if (prbs_on_w) begin
				mark_w = gen_bit_w ^ ber_pend_q;
			end else if (up_on_w) begin
				mark_w = (phase_q == 3'h4);
			end else if (down_on_w) begin
				mark_w = (phase_q == 3'h2);
			end else if (global_q[`GLB_SINGLE_RAIL_BIT]) begin
				mark_w = tx_positive_data_in_i[g];
			end else begin
				ami_w = 1'b0;
			end
		end

		assign ber_use_w = prbs_on_w && !ones_w && !remote_w;
		assign bpv_use_w = mark_w && ami_w && !remote_w && !ones_w
			&& (prbs_on_w || (global_q[`GLB_SINGLE_RAIL_BIT] && !up_on_w && !down_on_w));

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				phase_q <= 3'h0;
			end else if (tx_edge_w && !remote_w) begin
				if ((up_on_w && phase_q == 3'h4) || (down_on_w && phase_q == 3'h2)
					|| (!up_on_w && !down_on_w)) begin
					phase_q <= 3'h0;
				end else begin
					phase_q <= phase_q + 3'h1;
				end
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				tx_pos_q <= 1'b0;
				tx_neg_q <= 1'b0;
				last_pol_q <= 1'b0;
			end else if (edge_w) begin
				if (remote_w) begin
					tx_pos_q <= rx_pos_i[g];
					tx_neg_q <= rx_neg_i[g];
				end else if (!ami_w) begin
					tx_pos_q <= tx_positive_data_in_i[g];
					tx_neg_q <= tx_negative_data_in_i[g];
				end else if (mark_w) begin
					// A violation repeats the previous mark's polarity
					tx_pos_q <= bpv_use_w && bpv_pend_q ? !last_pol_q : last_pol_q;
					tx_neg_q <= bpv_use_w && bpv_pend_q ? last_pol_q : !last_pol_q;
					last_pol_q <= bpv_use_w && bpv_pend_q ? last_pol_q : !last_pol_q;
				end else begin
					tx_pos_q <= 1'b0;
					tx_neg_q <= 1'b0;
				end
			end
		end

		assign err_w = rx_s.step && (rx_s.bit_v != chk_bit_w);

		always_ff @(posedge clock_i) begin
			if (rst_i || !prbs_on_w) begin
				win_q <= 7'h00;
				errs_q <= 3'h0;
				synced_q <= 1'b0;
			end else if (rx_s.step) begin
				win_q <= win_q + 7'h01;
				if (win_q == `PRBS_WINDOW_LAST) begin
					errs_q <= 3'h0;
					synced_q <= (errs_q + {2'h0, err_w}) < `PRBS_ERR_LIMIT;
				end else if (err_w && errs_q != `PRBS_ERR_LIMIT) begin
					errs_q <= errs_q + 3'h1;
				end
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				prbs_flag_q <= 1'b0;
			end else begin
				prbs_flag_q <= synced_q && !err_w;
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				detected_prev_q <= 1'b0;
				flag_prev_q <= 1'b0;
				irq_q <= 1'b0;
			end else begin
				detected_prev_q <= detected_q;
				flag_prev_q <= prbs_flag_q;
				irq_q <= ((detected_q != detected_prev_q) && ctrl_q[g][`CTRL_LOOP_IE_BIT])
					|| ((prbs_flag_q != flag_prev_q) && ctrl_q[g][`CTRL_PRBS_IE_BIT]);
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				analog_q <= 1'b0;
				remote_q <= 1'b0;
				digital_q <= 1'b0;
			end else begin
				analog_q <= analog_w;
				remote_q <= remote_w;
				digital_q <= digital_w;
			end
		end

		assign stat_w[g] = {remote_q, prbs_flag_q, detected_q};
		assign tx_pos_o[g] = tx_pos_q;
		assign tx_neg_o[g] = tx_neg_q;
		assign analog_loop_o[g] = analog_q;
		assign remote_loop_o[g] = remote_q;
		assign digital_loop_o[g] = digital_q;
		assign irq_o[g] = irq_q;
	end
endmodule : line_test

// >>> design/line_test_cfg.svh
// Offsets, field positions, reset values and timing counts for the line test block
// Function
// - Pin-strapped: all-ones pin per channel sends all-ones
// - Pattern select: 0xx none, QRSS, ones, up, down
// - All-ones ignores data, AMI ones on transmit clock
// - Global auto all-ones on receive loss of signal
// - Loop-up selected sends repeating 00001
// - Loop-down selected sends repeating 001
// - Detect mode: off, up, down, automatic loopback
// - Manual detect: status after 5 s, held while code
// - Every detected-status change raises enabled interrupt
// - Automatic only if pattern not 110; clears status
// - Auto: up 5 s sets status, enables remote loop
// - Auto: down 5 s removes loop, clears status
// - Leaving automatic mode removes automatic remote loop
// - Analog loopback active: ignore remote loop requests
// - QRSS: T1 2^20-1 max 14 zeros, E1 inverted 2^15-1
// - Sync once 128-bit window has under 4 errors
// - After sync each error drops flag one cycle
// - Every sync flag transition raises enabled interrupt
// - Rising insert controls add one error or violation
// - Pin loopback select: none, analog, remote, digital
// - Remote loop returns receive data on receive clock
`ifndef LINE_TEST_CFG_SVH
`define LINE_TEST_CFG_SVH

`define CHANNELS 8
`define GLOBAL_OFS 8'h00
`define CH_BASE 8'h10
`define CH_SPAN 8'h40
`define GLB_E1_BIT 0
`define GLB_AUTO_ONES_BIT 1
`define GLB_SINGLE_RAIL_BIT 2
`define GLOBAL_RESET 3'h0
`define CTRL_RESET 12'h000
`define CTRL_INS_BER_BIT 8
`define CTRL_INS_BPV_BIT 9
`define CTRL_LOOP_IE_BIT 10
`define CTRL_PRBS_IE_BIT 11
`define PAT_QRSS 3'h4
`define PAT_ONES 3'h5
`define PAT_UP 3'h6
`define PAT_DOWN 3'h7
`define DET_OFF 2'h0
`define DET_UP 2'h1
`define DET_DOWN 2'h2
`define DET_AUTO 2'h3
`define LOOP_QUAL_S 5
`define T1_RATE_HZ 32'h0017_8f40
`define E1_RATE_HZ 32'h001f_4000
`define PRBS_WINDOW_LAST 7'h7f
`define PRBS_ERR_LIMIT 3'h4
`define PRBS_SEED 20'h00001

`endif

// >>> design/line_test_pkg.sv
// Types shared by the line test modules
package line_test_pkg;
	typedef enum {AUTO_OFF, AUTO_WATCH_UP, AUTO_LOOPED} auto_state_t;
	typedef enum {LB_NONE, LB_ANALOG, LB_REMOTE, LB_DIGITAL, LB_DUAL} loopback_t;
endpackage : line_test_pkg

// >>> design/loop_code_detector.sv
// Continuous loop-up or loop-down code matcher with qualification count
`timescale 1ns/1ps
`include "line_test_cfg.svh"
module loop_code_detector import line_test_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_i,
	bit_stream_if.snk rx,
	input wire logic want_down_i,
	input wire logic restart_i,
	input wire logic [23:0] limit_i,
	output logic qualified_o
);
	logic [4:0] hist_q;
	logic [23:0] count_q;
	logic match_w;

	// Period 5 with a single mark for 00001, period 3 for 001
	always_comb begin
		if (want_down_i) begin
			match_w = (rx.bit_v == hist_q[2]) && ($countones(hist_q[2:0]) == 1);
		end else begin
			match_w = (rx.bit_v == hist_q[4]) && ($countones(hist_q) == 1);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hist_q <= 5'h00;
		end else if (rx.step) begin
			hist_q <= {hist_q[3:0], rx.bit_v};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i || restart_i) begin
			count_q <= 24'h000000;
		end else if (rx.step) begin
			if (!match_w) begin
				count_q <= 24'h000000;
			end else if (count_q != limit_i) begin
				count_q <= count_q + 24'h000001;
			end
		end
	end

	assign qualified_o = (count_q == limit_i) && !restart_i;
endmodule : loop_code_detector

// >>> design/prbs_engine.sv
// QRSS sequence generator or self-synchronising checker
`timescale 1ns/1ps
`include "line_test_cfg.svh"
module prbs_engine import line_test_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_i,
	bit_stream_if.snk s,
	input wire logic e1_mode_i,
	input wire logic check_i,
	output logic bit_o
);
	logic [19:0] reg_q;
	logic fb_w;
	logic force_w;

	assign fb_w = e1_mode_i ? (reg_q[14] ^ reg_q[13]) : (reg_q[19] ^ reg_q[16]);
	// Forcing a one after 14 raw zeros bounds the zero run
	assign force_w = !e1_mode_i && (reg_q[13:0] == 14'h0000);
	assign bit_o = e1_mode_i ? !fb_w : (fb_w | force_w);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reg_q <= `PRBS_SEED;
		end else if (s.step) begin
			if (!check_i) begin
				reg_q <= {reg_q[18:0], fb_w};
			end else if (e1_mode_i) begin
				reg_q <= {reg_q[18:0], !s.bit_v};
			end else begin
				// A forced one carries no raw bit, so the predicted one is kept
				reg_q <= {reg_q[18:0], force_w ? fb_w : s.bit_v};
			end
		end
	end
endmodule : prbs_engine

// >>> tb/line_test_props.sv
// Port-level checks for the line test block
`timescale 1ns/1ps
module line_test_props (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic waitrequest_o,
	input wire logic host_mode_i,
	input wire logic [7:0] all_ones_request_pin_i,
	input wire logic [15:0] loop_pin_i,
	input wire logic [7:0] rx_clock_i,
	input wire logic [7:0] rx_pos_i,
	input wire logic [7:0] rx_neg_i,
	input wire logic [7:0] tx_pos_o,
	input wire logic [7:0] tx_neg_o,
	input wire logic [7:0] analog_loop_o,
	input wire logic [7:0] remote_loop_o,
	input wire logic [7:0] digital_loop_o,
	input wire logic [7:0] irq_o
);
	logic [4:0] ones_q;
	logic pin_mode;
	assign pin_mode = !host_mode_i;
	// Saturates well past two line-clock periods so the first mark has surely gone out
	always_ff @(posedge clock_i) begin
		if (rst_i || host_mode_i || !all_ones_request_pin_i[0] || loop_pin_i[1:0] != 2'b00) begin
			ones_q <= 5'h00;
		end else if (ones_q != 5'h1f) begin
			ones_q <= ones_q + 5'h01;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	bus_take_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("access not answered");
	bus_once_a: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("wait state dropped twice");
	pin_ones_a: assert property (ones_q == 5'h1f |-> (tx_pos_o[0] || tx_neg_o[0]))
		else $error("all-ones request without mark");
	ami_rail_a: assert property ((tx_pos_o & tx_neg_o) == 8'h00)
		else $error("both rails marked");
	loop_none_a: assert property ((pin_mode && loop_pin_i[1:0] == 2'b00) [*3] |->
		!analog_loop_o[0] && !remote_loop_o[0] && !digital_loop_o[0]) else $error("loop not off");
	loop_analog_a: assert property ((pin_mode && loop_pin_i[1:0] == 2'b01) [*3] |->
		analog_loop_o[0] && !remote_loop_o[0] && !digital_loop_o[0]) else $error("no analog");
	loop_remote_a: assert property ((pin_mode && loop_pin_i[1:0] == 2'b10) [*3] |->
		!analog_loop_o[0] && remote_loop_o[0] && !digital_loop_o[0]) else $error("no remote");
	loop_digital_a: assert property ((pin_mode && loop_pin_i[1:0] == 2'b11) [*3] |->
		!analog_loop_o[0] && !remote_loop_o[0] && digital_loop_o[0]) else $error("no digital");
	echo_mark_a: assert property (remote_loop_o[0] && $rose(rx_clock_i[0]) &&
		(rx_pos_i[0] || rx_neg_i[0]) |-> ##[1:2] (tx_pos_o[0] || tx_neg_o[0] || !remote_loop_o[0]))
		else $error("received mark not returned");
	analog_block_a: assert property (analog_loop_o[0] && $past(analog_loop_o[0]) |->
		!$rose(remote_loop_o[0])) else $error("remote loop taken during analog loop");
	reset_state_a: assert property (disable iff (1'b0) rst_i |=>
		waitrequest_o && irq_o == 8'h00 && remote_loop_o == 8'h00) else $error("reset state");
endmodule : line_test_props

bind line_test line_test_props i_props (.clock_i, .rst_i, .read_i, .write_i, .waitrequest_o,
	.host_mode_i, .all_ones_request_pin_i, .loop_pin_i, .rx_clock_i, .rx_pos_i, .rx_neg_i,
	.tx_pos_o, .tx_neg_o, .analog_loop_o, .remote_loop_o, .digital_loop_o, .irq_o);

// >>> tb/line_test_tb_top.sv
// Self-checking bench for the line test block
`timescale 1ns/1ps
`include "line_test_cfg.svh"
module line_test_tb_top;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] address_i = 8'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0;
	logic host_mode_i = 1'b0;
	logic auto_ones = 1'b0;
	logic [7:0] ones_pin = 8'h00;
	logic [15:0] loop_pin = 16'h0000;
	logic [7:0] los = 8'h00;
	logic [1:0] far_mode = 2'h0;
	logic [31:0] readdata_o;
	logic waitrequest_o, tx_clk, rx_clk, rx_p, rx_n;
	logic [7:0] tx_pos_o, tx_neg_o, an_lp, rm_lp, dg_lp, irq_o;
	logic [2:0] lp_exp [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
	logic [2:0] pat [4] = '{3'b011, `PAT_ONES, `PAT_UP, `PAT_DOWN};
	int pat_marks [4] = '{0, 15, 3, 5};
	int n_fail = 0, compares = 0, irq_cnt = 0, marks0 = 0, pos0 = 0, marks1 = 0;
	int zrun = 0, zmax = 0, viol0 = 0;
	logic lastp0 = 1'b0;
	always #20 clock_i = ~clock_i;
	line_test #(.QUAL_T1_CYCLES(20), .QUAL_E1_CYCLES(20)) i_dut (.clock_i, .rst_i, .address_i,
		.read_i, .write_i, .writedata_i, .byteenable_i(4'hf), .readdata_o, .waitrequest_o,
		.host_mode_i, .auto_all_ones_pin_i(auto_ones), .all_ones_request_pin_i(ones_pin),
		.loop_pin_i(loop_pin), .receive_loss_of_signal_i(los), .tx_line_clock_i({8{tx_clk}}),
		.tx_positive_data_in_i(8'h00), .tx_negative_data_in_i(8'h00), .rx_clock_i({8{rx_clk}}),
		.rx_pos_i({7'h00, rx_p}), .rx_neg_i({7'h00, rx_n}), .tx_pos_o, .tx_neg_o,
		.analog_loop_o(an_lp), .remote_loop_o(rm_lp), .digital_loop_o(dg_lp), .irq_o);
	remote_terminal i_far (.clock_i, .mode_i(far_mode), .tx_pos_i(tx_pos_o[0]),
		.tx_neg_i(tx_neg_o[0]), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rx_pos_o(rx_p),
		.rx_neg_o(rx_n));
	always @(posedge clock_i) if (irq_o[0] === 1'b1) irq_cnt++;
	// Bits are read mid-period, long after the output update
	always @(negedge tx_clk) begin
		marks0 += (tx_pos_o[0] | tx_neg_o[0]);
		pos0 += tx_pos_o[0];
		marks1 += (tx_pos_o[1] | tx_neg_o[1]);
		zrun = (tx_pos_o[0] | tx_neg_o[0]) ? 0 : zrun + 1;
		// Two marks in a row with one polarity is a bipolar violation
		if (tx_pos_o[0] | tx_neg_o[0]) begin
			viol0 += (tx_pos_o[0] == lastp0);
			lastp0 = tx_pos_o[0];
		end
		if (zrun > zmax) zmax = zrun;
	end
	task automatic end_sim;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		address_i <= a;
		writedata_i <= d;
		read_i <= !wr;
		write_i <= wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 100);
		if (n >= 100) n_fail++;
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e, m);
	endtask : rd
	task automatic bits(input int n);
		repeat (n * 8) @(posedge clock_i);
	endtask : bits
	task automatic clr;
		marks0 = 0;
		pos0 = 0;
		marks1 = 0;
	endtask : clr
	initial begin
		repeat (90000) @(posedge clock_i);
		n_fail++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		ones_pin <= 8'h01;
		bits(4);
		clr();
		bits(20);
		check(32'(marks0), 32'd20, "pin all-ones");
		check(32'(pos0), 32'd10, "ami alternation");
		check(32'(marks1), 32'd0, "other channel");
		ones_pin <= 8'h00;
		auto_ones <= 1'b1;
		los <= 8'h01;
		bits(5);
		clr();
		bits(15);
		check(32'(marks0), 32'd15, "pin auto all-ones on loss");
		auto_ones <= 1'b0;
		los <= 8'h00;
		for (int v = 0; v < 4; v++) begin
			loop_pin <= {14'h0000, v[1:0]};
			repeat (4) @(posedge clock_i);
			check(32'({dg_lp[0], rm_lp[0], an_lp[0]}), 32'(lp_exp[v]), "pin loopback");
		end
		loop_pin <= 16'h0000;
		host_mode_i <= 1'b1;
		@(posedge clock_i);
		rd(8'h00, 32'h0, "global reset");
		rd(8'h10, 32'h0, "ctrl reset");
		rd(8'h14, 32'h0, "status reset");
		wr(8'hf0, 32'hffff_ffff);
		rd(8'hf0, 32'h0, "unmapped");
		wr(8'h14, 32'h7);
		rd(8'h14, 32'h0, "status read-only");
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h7, "global fields");
		wr(8'h00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, 32'(pat[i]));
			bits(5);
			clr();
			bits(15);
			check(32'(marks0), 32'(pat_marks[i]), "pattern marks");
		end
		wr(8'h10, 32'h0);
		wr(8'h00, 32'h2);
		los <= 8'h01;
		bits(5);
		clr();
		bits(15);
		check(32'(marks0), 32'd15, "auto all-ones on loss");
		los <= 8'h00;
		wr(8'h00, 32'h0);
		// Host answers nothing itself here, it only watches the status
		for (int i = 1; i < 3; i++) begin
			far_mode <= 2'(i);
			wr(8'h10, 32'(i << 3) | 32'h400);
			irq_cnt = 0;
			bits(40);
			rd(8'h14, 32'h1, "manual detect");
			far_mode <= 2'h0;
			bits(10);
			rd(8'h14, 32'h0, "manual release");
			check(32'(irq_cnt), 32'd2, "loop irq");
		end
		far_mode <= 2'h1;
		wr(8'h10, 32'h418);
		irq_cnt = 0;
		bits(40);
		rd(8'h14, 32'h5, "auto loop up");
		far_mode <= 2'h0;
		bits(10);
		rd(8'h14, 32'h5, "auto loop held");
		far_mode <= 2'h2;
		bits(40);
		rd(8'h14, 32'h0, "auto loop down");
		check(32'(irq_cnt), 32'd2, "auto irq");
		far_mode <= 2'h1;
		bits(40);
		check(32'(rm_lp), 32'h1, "auto loop again");
		wr(8'h10, 32'h0);
		repeat (2) @(posedge clock_i);
		check(32'(rm_lp), 32'h0, "leave auto");
		wr(8'h10, 32'h1e);
		bits(40);
		check(32'(rm_lp), 32'h0, "auto while sending up");
		wr(8'h10, 32'hb8);
		bits(40);
		check(32'(rm_lp), 32'h0, "auto under analog loop");
		wr(8'h10, 32'h0);
		far_mode <= 2'h3;
		for (int e = 0; e < 2; e++) begin
			wr(8'h00, 32'(e));
			bits(300);
			wr(8'h10, 32'h804);
			irq_cnt = 0;
			bits(20);
			zrun = 0;
			zmax = 0;
			bits(680);
			rd(8'h14, 32'h2, "prbs sync");
			check(32'(irq_cnt), 32'd1, "sync irq");
			if (e == 0) check(32'(zmax <= 14), 32'h1, "zero run");
			irq_cnt = 0;
			wr(8'h10, 32'h904);
			bits(300);
			check(32'(irq_cnt[0] == 1'b0 && irq_cnt >= 2), 32'h1, "error pulses");
			rd(8'h14, 32'h2, "sync kept");
			viol0 = 0;
			wr(8'h10, 32'ha04);
			bits(100);
			check(32'(viol0), 32'd1, "one violation");
			wr(8'h10, 32'h0);
		end
		end_sim();
	end
endmodule : line_test_tb_top

// >>> tb/remote_terminal.sv
// Far-end terminal: line clocks, loop codes, or AMI echo of our transmit channel 0
`timescale 1ns/1ps
module remote_terminal (
	input wire logic clock_i,
	input wire logic [1:0] mode_i,
	input wire logic tx_pos_i,
	input wire logic tx_neg_i,
	output logic tx_clk_o,
	output logic rx_clk_o,
	output logic rx_pos_o,
	output logic rx_neg_o
);
	logic [2:0] ph_q;
	logic [2:0] idx_q;
	logic pol_q;
	logic mark;
	initial begin
		{ph_q, idx_q, pol_q, tx_clk_o, rx_clk_o, rx_pos_o, rx_neg_o} = '0;
	end
	always_comb begin
		case (mode_i)
			2'h1: mark = (idx_q == 3'h4);
			2'h2: mark = (idx_q == 3'h2);
			2'h3: mark = tx_pos_i | tx_neg_i;
			default: mark = 1'b0;
		endcase
	end
	// Receive clock lags transmit by five cycles so the echo reads a settled bit
	always @(posedge clock_i) begin
		ph_q <= ph_q + 3'h1;
		tx_clk_o <= ph_q[2];
		rx_clk_o <= (ph_q >= 3'h1) && (ph_q < 3'h5);
		if (ph_q == 3'h6) begin
			idx_q <= (idx_q >= ((mode_i == 2'h1) ? 3'h4 : 3'h2)) ? 3'h0 : idx_q + 3'h1;
			pol_q <= pol_q ^ mark;
			rx_pos_o <= mark && !pol_q;
			rx_neg_o <= mark && pol_q;
		end
	end
endmodule : remote_terminal
